// File: logic/sram_port_pkg.sv
// constants, field layouts and carrier types for the burst sram port
package sram_port_pkg;

    // ------------------------------------------------------------------
    // widths of the narrow variant
    // ------------------------------------------------------------------
    localparam int WORD_W     = 18;
    localparam int BYTE_W     = 9;
    localparam int NUM_BYTES  = 2;
    localparam int BURST_LEN  = 2;
    localparam int ADDR_W     = 19;
    localparam int BANK_DEPTH = 2 ** ADDR_W;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              load_n;
        logic              rw;
        logic [ADDR_W-1:0] addr;
    } cmd_t;

    typedef struct packed {
        logic [WORD_W-1:0]    data;
        logic [NUM_BYTES-1:0] sel_n;
    } beat_t;

    typedef logic [BURST_LEN-1:0][WORD_W-1:0] burst_words_t;

    typedef enum logic {
        LAT_ONE,
        LAT_LONG
    } lat_mode_t;

    typedef enum logic {
        SLOT_OPEN,
        SLOT_SECOND
    } slot_t;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam cmd_t  CMD_RST   = '{load_n: 1'b1, rw: 1'b1,
                                    addr: {ADDR_W{1'b0}}};
    localparam beat_t BEAT_RST  = '{data: {WORD_W{1'b0}},
                                    sel_n: {NUM_BYTES{1'b1}}};
    localparam logic [WORD_W-1:0] WORD_RST = 18'h00000;

endpackage : sram_port_pkg

// File: logic/burst_bank_array.sv
// two-bank storage array with per-byte write enables
`timescale 1ns/100ps
module burst_bank_array
    import sram_port_pkg::*;
(
    input  wire logic                       clk_in,
    input  wire logic                       wr_en_in,
    input  wire logic [ADDR_W-1:0]          wr_addr_in,
    input  wire beat_t [BURST_LEN-1:0]      wr_beats_in,
    input  wire logic [ADDR_W-1:0]          rd_addr_in,
    output burst_words_t                    rd_words_out
);

    // bank 0 holds the first word of each burst, bank 1 the second
    for (genvar b = 0; b < BURST_LEN; b++) begin : g_bank
        for (genvar j = 0; j < NUM_BYTES; j++) begin : g_byte
            logic [BYTE_W-1:0] mem [BANK_DEPTH];

            always_ff @(posedge clk_in) begin
                if (wr_en_in && !wr_beats_in[b].sel_n[j]) begin
                    mem[wr_addr_in] <=
                        wr_beats_in[b].data[j*BYTE_W +: BYTE_W];
                end
            end

            assign rd_words_out[b][j*BYTE_W +: BYTE_W] = mem[rd_addr_in];
        end
    end

endmodule : burst_bank_array

// File: logic/event_toggle_sync.sv
// toggle crossing of a one-cycle event into another clock domain
`timescale 1ns/100ps
module event_toggle_sync (
    input  wire logic src_clk_in,
    input  wire logic src_rst_in,
    input  wire logic src_pulse_in,
    input  wire logic dst_clk_in,
    input  wire logic dst_rst_in,
    output logic      dst_pulse_out
);

    logic toggle_ff;
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    always_ff @(posedge src_clk_in or posedge src_rst_in) begin
        if (src_rst_in) begin
            toggle_ff <= 1'b0;
        end else if (src_pulse_in) begin
            toggle_ff <= ~toggle_ff;
        end
    end

    always_ff @(posedge dst_clk_in or posedge dst_rst_in) begin
        if (dst_rst_in) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= toggle_ff;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign dst_pulse_out = sync_ff ^ last_ff;

endmodule : event_toggle_sync

// File: logic/ddr_two_word_burst_sram_port.sv
// double-rate two-word burst sram port: link pipeline, storage, echo
//
// Summary of operation
// - a new address is taken at most on every second primary edge
// - write words arrive on primary then complementary edge; both kept
// - read words leave on primary and complementary edges, one each
// - each address carries exactly two 18-bit words in sequence
// - latency pin high: read data appears 2.5 cycles after address
// - latency pin low: read data appears one cycle after address
// - read-valid flag is high while read data is on the pins
// - complementary echo clocks are aligned with read data
// - read and write share the data pins; controller releases them
// - every synchronous input is caught by an input flip-flop
// - every data output is launched from an output flip-flop
// - writes complete internally, no extra strobes needed
// - only rising edges of both input clocks are used
// - narrow variant: one million 18-bit words, 19-bit burst address
// - low byte selects write a byte; select zero covers bits 8..0
// - data drivers float whenever no read is in progress
`timescale 1ns/100ps
module ddr_two_word_burst_sram_port
    import sram_port_pkg::*;
(
    input  wire logic                 ref_clk_in,
    input  wire logic                 sys_rst_in,
    input  wire logic                 k_clk_in,
    input  wire logic                 kn_clk_in,
    input  wire logic                 load_strobe_n_in,
    input  wire logic                 read_not_write_in,
    input  wire logic [ADDR_W-1:0]    addr_in,
    input  wire logic [NUM_BYTES-1:0] byte_write_select_n_in,
    input  wire logic [WORD_W-1:0]    dq_in,
    output logic      [WORD_W-1:0]    dq_out,
    output logic                      dq_oe_out,
    input  wire logic                 latency_mode_pin_in,
    output logic                      echo_clock_out,
    output logic                      echo_clock_n_out,
    output logic                      read_valid_flag_out,
    output logic                      rd_event_out,
    output logic                      wr_event_out
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic         k_rst_meta_ff;
    logic         k_rst_ff;
    logic         lat_meta_ff;
    logic         lat_sync_ff;
    lat_mode_t    lat_mode;

    cmd_t         cmd_q_ff;
    beat_t        beat_k_q_ff;
    beat_t        beat_kn_q_ff;

    slot_t        slot_ff;
    slot_t        nxt_slot;
    logic         accept;
    logic         rd_go;
    logic         wr_go;
    logic         rd_short_go;
    logic         rd_long_go;

    logic              wr_pend_ff;
    logic [ADDR_W-1:0] wr_addr_ff;
    beat_t [BURST_LEN-1:0] wr_beats;
    burst_words_t      rd_words;

    burst_words_t      hold_ff;
    logic              hold_go_ff;
    logic [WORD_W-1:0] k_next_ff;
    logic              k_next_go_ff;
    logic [WORD_W-1:0] q_k_ff;
    logic              vk_ff;
    logic [WORD_W-1:0] kn_word_ff;
    logic              kn_go_ff;
    logic [WORD_W-1:0] q_kn_ff;
    logic              vkn_ff;

    // ------------------------------------------------------------------
    // link reset: asynchronous assert, release on the primary clock
    // ------------------------------------------------------------------
    always_ff @(posedge k_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            k_rst_meta_ff <= 1'b1;
            k_rst_ff      <= 1'b1;
        end else begin
            k_rst_meta_ff <= 1'b0;
            k_rst_ff      <= k_rst_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // latency pin is static and asynchronous: two stages
    // ------------------------------------------------------------------
    always_ff @(posedge k_clk_in or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            lat_meta_ff <= 1'b0;
            lat_sync_ff <= 1'b0;
        end else begin
            lat_meta_ff <= latency_mode_pin_in;
            lat_sync_ff <= lat_meta_ff;
        end
    end

    assign lat_mode = lat_sync_ff ? LAT_LONG : LAT_ONE;

    // ------------------------------------------------------------------
    // input flip-flops on the primary clock
    // ------------------------------------------------------------------
    always_ff @(posedge k_clk_in or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            cmd_q_ff <= CMD_RST;
        end else begin
            cmd_q_ff <= '{load_n: load_strobe_n_in,
                          rw:   read_not_write_in,
                          addr: addr_in};
        end
    end

    always_ff @(posedge k_clk_in or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            beat_k_q_ff <= BEAT_RST;
        end else begin
            beat_k_q_ff <= '{data: dq_in,
                             sel_n: byte_write_select_n_in};
        end
    end

    // ------------------------------------------------------------------
    // input flip-flops on the complementary clock
    // ------------------------------------------------------------------
    always_ff @(posedge kn_clk_in or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            beat_kn_q_ff <= BEAT_RST;
        end else begin
            beat_kn_q_ff <= '{data: dq_in,
                              sel_n: byte_write_select_n_in};
        end
    end

    // ------------------------------------------------------------------
    // address slot: a load is honoured only in an open slot
    // ------------------------------------------------------------------
    always_comb begin
        nxt_slot = slot_ff;
        case (slot_ff)
            SLOT_OPEN: begin
                if (!cmd_q_ff.load_n) begin
                    nxt_slot = SLOT_SECOND;
                end
            end
            SLOT_SECOND: begin
                nxt_slot = SLOT_OPEN;
            end
            default: begin
                nxt_slot = SLOT_OPEN;
            end
        endcase
    end

    always_ff @(posedge k_clk_in or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            slot_ff <= SLOT_OPEN;
        end else begin
            slot_ff <= nxt_slot;
        end
    end

    assign accept      = (slot_ff == SLOT_OPEN) && !cmd_q_ff.load_n;
    assign rd_go       = accept && cmd_q_ff.rw;
    assign wr_go       = accept && !cmd_q_ff.rw;
    assign rd_short_go = rd_go && (lat_mode == LAT_ONE);
    assign rd_long_go  = rd_go && (lat_mode == LAT_LONG);

    // ------------------------------------------------------------------
    // self-timed write: both words committed one cycle after decode
    // ------------------------------------------------------------------
    always_ff @(posedge k_clk_in or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= {ADDR_W{1'b0}};
        end else begin
            wr_pend_ff <= wr_go;
            if (wr_go) begin
                wr_addr_ff <= cmd_q_ff.addr;
            end
        end
    end

    // first word from the primary edge, second from the complementary
    assign wr_beats[0] = beat_k_q_ff;
    assign wr_beats[1] = beat_kn_q_ff;

    burst_bank_array u_array (
        .clk_in       (k_clk_in),
        .wr_en_in     (wr_pend_ff),
        .wr_addr_in   (wr_addr_ff),
        .wr_beats_in  (wr_beats),
        .rd_addr_in   (cmd_q_ff.addr),
        .rd_words_out (rd_words)
    );

    // ------------------------------------------------------------------
    // read pipeline for the long latency mode
    // ------------------------------------------------------------------
    always_ff @(posedge k_clk_in or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            hold_ff    <= {BURST_LEN{WORD_RST}};
            hold_go_ff <= 1'b0;
        end else begin
            hold_go_ff <= rd_long_go;
            if (rd_long_go) begin
                hold_ff <= rd_words;
            end
        end
    end

    always_ff @(posedge k_clk_in or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            k_next_ff    <= WORD_RST;
            k_next_go_ff <= 1'b0;
        end else begin
            k_next_go_ff <= hold_go_ff;
            if (hold_go_ff) begin
                k_next_ff <= hold_ff[1];
            end
        end
    end

    // ------------------------------------------------------------------
    // primary-edge output flip-flops
    // ------------------------------------------------------------------
    always_ff @(posedge k_clk_in or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            q_k_ff <= WORD_RST;
            vk_ff  <= 1'b0;
        end else if (rd_short_go) begin
            q_k_ff <= rd_words[0];
            vk_ff  <= 1'b1;
        end else if (k_next_go_ff) begin
            q_k_ff <= k_next_ff;
            vk_ff  <= 1'b1;
        end else begin
            vk_ff  <= 1'b0;
        end
    end

    // word for the next complementary edge, chosen on the primary clock
    always_ff @(posedge k_clk_in or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            kn_word_ff <= WORD_RST;
            kn_go_ff   <= 1'b0;
        end else if (rd_short_go) begin
            kn_word_ff <= rd_words[1];
            kn_go_ff   <= 1'b1;
        end else if (hold_go_ff) begin
            kn_word_ff <= hold_ff[0];
            kn_go_ff   <= 1'b1;
        end else begin
            kn_go_ff   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // complementary-edge output flip-flops
    // ------------------------------------------------------------------
    always_ff @(posedge kn_clk_in or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            q_kn_ff <= WORD_RST;
            vkn_ff  <= 1'b0;
        end else begin
            q_kn_ff <= kn_word_ff;
            vkn_ff  <= kn_go_ff;
        end
    end

    // ------------------------------------------------------------------
    // pins: each half-cycle shows the flop launched at its rising edge
    // ------------------------------------------------------------------
    assign dq_out              = k_clk_in ? q_k_ff : q_kn_ff;
    assign dq_oe_out           = k_clk_in ? vk_ff : vkn_ff;
    assign read_valid_flag_out = k_clk_in ? vk_ff : vkn_ff;
    assign echo_clock_out      = k_clk_in;
    assign echo_clock_n_out    = kn_clk_in;

    // ------------------------------------------------------------------
    // transaction events toward the system clock
    // ------------------------------------------------------------------
    event_toggle_sync u_rd_event (
        .src_clk_in    (k_clk_in),
        .src_rst_in    (k_rst_ff),
        .src_pulse_in  (rd_go),
        .dst_clk_in    (ref_clk_in),
        .dst_rst_in    (sys_rst_in),
        .dst_pulse_out (rd_event_out)
    );

    event_toggle_sync u_wr_event (
        .src_clk_in    (k_clk_in),
        .src_rst_in    (k_rst_ff),
        .src_pulse_in  (wr_go),
        .dst_clk_in    (ref_clk_in),
        .dst_rst_in    (sys_rst_in),
        .dst_pulse_out (wr_event_out)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_addr_alternate: assert property (
        @(posedge k_clk_in) disable iff (k_rst_ff)
        accept |=> !accept)
        else $error("address accepted on two adjacent edges");

    a_write_commit: assert property (
        @(posedge k_clk_in) disable iff (k_rst_ff)
        wr_go |=> (wr_pend_ff && wr_addr_ff == $past(cmd_q_ff.addr))
                  ##1 !wr_pend_ff)
        else $error("write not committed once one cycle after decode");

    a_short_first_word: assert property (
        @(posedge k_clk_in) disable iff (k_rst_ff)
        rd_short_go |=> vk_ff && q_k_ff == $past(rd_words[0]))
        else $error("short latency first word not launched");

    a_short_second_word: assert property (
        @(posedge k_clk_in) disable iff (k_rst_ff)
        rd_short_go |=> kn_go_ff && kn_word_ff == $past(rd_words[1]))
        else $error("short latency second word not staged");

    a_long_latency: assert property (
        @(posedge k_clk_in) disable iff (k_rst_ff)
        rd_long_go |=> hold_go_ff ##1 (kn_go_ff && !vk_ff) ##1 vk_ff)
        else $error("long latency read timing wrong");

    a_long_word_order: assert property (
        @(posedge k_clk_in) disable iff (k_rst_ff)
        rd_long_go |=> ##1 kn_word_ff == $past(rd_words[0], 2)
                       ##1 q_k_ff == $past(rd_words[1], 3))
        else $error("long latency burst order wrong");

    a_valid_cause: assert property (
        @(posedge k_clk_in) disable iff (k_rst_ff)
        vk_ff |-> $past(rd_short_go) || $past(rd_long_go, 3))
        else $error("valid flag without a read in flight");

    a_kn_launch: assert property (
        @(posedge kn_clk_in) disable iff (k_rst_ff)
        kn_go_ff |=> vkn_ff && q_kn_ff == $past(kn_word_ff))
        else $error("complementary word not launched");

    a_kn_float: assert property (
        @(posedge kn_clk_in) disable iff (k_rst_ff)
        !kn_go_ff |=> !vkn_ff)
        else $error("driver enabled with no read word");

endmodule : ddr_two_word_burst_sram_port

// File: test/sram_ctrl_model.sv
// controller-side model: drives link commands and captures read bursts
`timescale 1ns/100ps
module sram_ctrl_model
    import sram_port_pkg::*;
(
    input  wire logic                 k_clk_in,
    input  wire logic                 kn_clk_in,
    input  wire logic                 echo_clock_in,
    input  wire logic                 echo_clock_n_in,
    input  wire logic                 read_valid_in,
    input  wire logic [WORD_W-1:0]    dq_pin_in,
    output logic                      load_strobe_n_out,
    output logic                      read_not_write_out,
    output logic [ADDR_W-1:0]         addr_out,
    output logic [NUM_BYTES-1:0]      byte_sel_n_out,
    output logic [WORD_W-1:0]         dq_drive_out
);
    logic [WORD_W-1:0] cap_q[$];
    int                dist_q[$];
    int                hcnt = 0;
    int                load_h = 0;

    initial begin
        load_strobe_n_out  = 1'b1;
        read_not_write_out = 1'b1;
        addr_out           = '0;
        byte_sel_n_out     = '1;
        dq_drive_out       = '0;
    end

    // half-cycle count, used to measure read latency
    always @(posedge k_clk_in or posedge kn_clk_in) begin
        hcnt <= hcnt + 1;
    end

    // sample mid-word after each echo edge, only while flagged valid
    always @(posedge echo_clock_in or posedge echo_clock_n_in) begin
        #3;
        if (read_valid_in === 1'b1) begin
            cap_q.push_back(dq_pin_in);
            dist_q.push_back(hcnt - load_h);
        end
    end

    // one transaction; hold keeps the load low for that many k edges
    task automatic xfer(input logic rnw, input logic [ADDR_W-1:0] a,
                        input beat_t b0, input beat_t b1, input int hold);
        @(posedge k_clk_in);
        #2;
        load_strobe_n_out  = 1'b0;
        read_not_write_out = rnw;
        addr_out           = a;
        @(posedge k_clk_in);
        #1;
        load_h = hcnt;
        repeat (hold - 1) @(posedge k_clk_in);
        #1;
        load_strobe_n_out = 1'b1;
        addr_out          = ~a;
        if (!rnw) begin
            dq_drive_out = b0.data;
            byte_sel_n_out = b0.sel_n;
            @(posedge k_clk_in);
            #2;
            dq_drive_out = b1.data;
            byte_sel_n_out = b1.sel_n;
            @(posedge kn_clk_in);
            #2;
            byte_sel_n_out = '1;
        end
        dq_drive_out = ~dq_drive_out;
    endtask : xfer
endmodule : sram_ctrl_model

// File: test/tb_top.sv
// self-checking bench for the burst sram port
`timescale 1ns/100ps
module tb_top;
    import sram_port_pkg::*;

    typedef struct {
        logic              lat;
        logic              rnw;
        logic [ADDR_W-1:0] a;
        beat_t             b0;
        beat_t             b1;
    } row_t;

    logic                 ref_clk = 1'b0;
    logic                 sys_rst = 1'b1;
    logic                 k_clk   = 1'b0;
    logic                 lat_pin = 1'b1;
    wire logic            kn_clk;
    wire logic            load_n, rnw, echo, echo_n, valid, oe, rd_ev, wr_ev;
    wire logic [ADDR_W-1:0]    addr;
    wire logic [NUM_BYTES-1:0] sel_n;
    wire logic [WORD_W-1:0]    dq_drv, dq_q, dq_pin;
    int                   n_fail = 0, n_tests = 0, n_rd = 0, n_wr = 0;
    int                   exp_rd = 0, exp_wr = 0;
    burst_words_t         mem [int];
    row_t                 rows [8];

    assign kn_clk = ~k_clk;
    assign dq_pin = (oe === 1'b1) ? dq_q : dq_drv;

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        #7.3;
        forever #6 k_clk = ~k_clk;
    end

    ddr_two_word_burst_sram_port uut (
        .ref_clk_in(ref_clk), .sys_rst_in(sys_rst), .k_clk_in(k_clk),
        .kn_clk_in(kn_clk), .load_strobe_n_in(load_n),
        .read_not_write_in(rnw), .addr_in(addr),
        .byte_write_select_n_in(sel_n), .dq_in(dq_pin), .dq_out(dq_q),
        .dq_oe_out(oe), .latency_mode_pin_in(lat_pin),
        .echo_clock_out(echo), .echo_clock_n_out(echo_n),
        .read_valid_flag_out(valid), .rd_event_out(rd_ev),
        .wr_event_out(wr_ev));

    sram_ctrl_model ctrl (
        .k_clk_in(k_clk), .kn_clk_in(kn_clk), .echo_clock_in(echo),
        .echo_clock_n_in(echo_n), .read_valid_in(valid),
        .dq_pin_in(dq_pin), .load_strobe_n_out(load_n),
        .read_not_write_out(rnw), .addr_out(addr), .byte_sel_n_out(sel_n),
        .dq_drive_out(dq_drv));

    always @(posedge ref_clk) begin
        if (rd_ev === 1'b1) n_rd++;
        if (wr_ev === 1'b1) n_wr++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    function automatic logic [WORD_W-1:0] merge(
        input logic [WORD_W-1:0] old, input beat_t b);
        merge = old;
        for (int i = 0; i < NUM_BYTES; i++) begin
            if (!b.sel_n[i]) begin
                merge[i*BYTE_W +: BYTE_W] = b.data[i*BYTE_W +: BYTE_W];
            end
        end
    endfunction : merge

    task automatic set_lat(input logic lat);
        if (lat_pin !== lat) begin
            @(negedge ref_clk);
            lat_pin = lat;
            repeat (10) @(posedge k_clk);
        end
    endtask : set_lat

    task automatic run_row(input row_t r);
        set_lat(r.lat);
        ctrl.xfer(r.rnw, r.a, r.b0, r.b1, 1);
        repeat (20) @(posedge k_clk);
        // look at the pins on the falling primary edge, where the complementary flops launch
        @(negedge k_clk);
        check(ctrl.cap_q.size(), r.rnw ? 2 : 0, "word count");
        check(oe, 1'b0, "drive left on");
        check(valid, 1'b0, "valid left on");
        if (r.rnw && ctrl.cap_q.size() == 2) begin
            for (int i = 0; i < 2; i++) begin
                check(ctrl.cap_q.pop_front(), mem[r.a][i], "data");
                check(ctrl.dist_q.pop_front(), (r.lat ? 5 : 2) + i,
                      "latency");
            end
        end else if (!r.rnw) begin
            if (!mem.exists(r.a)) mem[r.a] = 'x;
            mem[r.a][0] = merge(mem[r.a][0], r.b0);
            mem[r.a][1] = merge(mem[r.a][1], r.b1);
        end
        ctrl.cap_q.delete();
        ctrl.dist_q.delete();
    endtask : run_row

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #50us;
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        rows = '{
            '{1'b1, 1'b0, 19'h00000, '{18'h3FFFF, 2'h0}, '{18'h00001, 2'h0}},
            '{1'b1, 1'b0, 19'h7FFFF, '{18'h2AAAA, 2'h0}, '{18'h15555, 2'h0}},
            '{1'b1, 1'b0, 19'h7FFFF, '{18'h00000, 2'h1}, '{18'h3FFFF, 2'h2}},
            '{1'b1, 1'b1, 19'h00000, '{18'h00000, 2'h3}, '{18'h00000, 2'h3}},
            '{1'b1, 1'b1, 19'h7FFFF, '{18'h00000, 2'h3}, '{18'h00000, 2'h3}},
            '{1'b0, 1'b1, 19'h7FFFF, '{18'h00000, 2'h3}, '{18'h00000, 2'h3}},
            '{1'b0, 1'b0, 19'h00000, '{18'h12345, 2'h3}, '{18'h0F0F0, 2'h0}},
            '{1'b0, 1'b1, 19'h00000, '{18'h00000, 2'h3}, '{18'h00000, 2'h3}}};
        repeat (10) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (8) @(posedge k_clk);
        foreach (rows[i]) begin
            run_row(rows[i]);
            exp_rd += rows[i].rnw;
            exp_wr += !rows[i].rnw;
        end
        check(n_rd, exp_rd, "read events");
        check(n_wr, exp_wr, "write events");
        $display("test rows done");
        // load held low three edges: middle one refused, outer two taken
        set_lat(1'b1);
        ctrl.xfer(1'b1, 19'h7FFFF, BEAT_RST, BEAT_RST, 3);
        repeat (20) @(posedge k_clk);
        check(ctrl.cap_q.size(), 4, "back to back count");
        if (ctrl.cap_q.size() == 4) begin
            for (int j = 0; j < 4; j++) begin
                check(ctrl.cap_q.pop_front(), mem[19'h7FFFF][j % 2],
                      "back to back data");
                check(ctrl.dist_q.pop_front(), 5 + j + 2 * (j / 2),
                      "back to back latency");
            end
        end
        ctrl.cap_q.delete();
        ctrl.dist_q.delete();
        $display("test refused load done");
        @(negedge ref_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        check(oe, 1'b0, "reset drive");
        check(valid, 1'b0, "reset valid");
        check(dq_q, 18'h00000, "reset data");
        check(echo, k_clk, "echo clock");
        check(echo_n, kn_clk, "echo clock inverse");
        sys_rst = 1'b0;
        repeat (8) @(posedge k_clk);
        run_row(rows[3]);
        $display("test reset done");
        finish_test();
    end
endmodule : tb_top
